// file: common/spp_pkg.sv
`default_nettype none
package spp_pkg;

   // ************************************************
   // Register byte addresses
   // ************************************************
   localparam logic [7:0] SPP_E_DATA    = 8'h00;
   localparam logic [7:0] SPP_E_DIR     = 8'h04;
   localparam logic [7:0] SPP_F_DATA    = 8'h08;
   localparam logic [7:0] SPP_F_DIR     = 8'h0c;
   localparam logic [7:0] SPP_G_DATA    = 8'h10;
   localparam logic [7:0] SPP_G_DIR     = 8'h14;
   localparam logic [7:0] SPP_G_PULLUP  = 8'h18;
   localparam logic [7:0] SPP_CTL       = 8'h1c;
   localparam logic [7:0] SPP_DISP_EN5  = 8'h20;
   localparam logic [7:0] SPP_DISP_EN6  = 8'h24;
   // Latch views, the way a read-modify-write instruction reads
   localparam logic [7:0] SPP_E_RMW     = 8'h40;
   localparam logic [7:0] SPP_F_RMW     = 8'h48;
   localparam logic [7:0] SPP_G_RMW     = 8'h50;

   // ************************************************
   // Implemented bits
   // ************************************************
   localparam logic [7:0] SPP_E_MASK    = 8'hff;
   localparam logic [7:0] SPP_F_MASK    = 8'h07;
   localparam logic [7:0] SPP_G_MASK    = 8'h06;
   localparam logic [7:0] SPP_EN5_MASK  = 8'h03;
   localparam logic [7:0] SPP_EN6_MASK  = 8'h3f;
   localparam logic [7:0] SPP_CTL_MASK  = 8'h03;
   localparam int         SPP_CTL_PORT_IN   = 0;
   localparam int         SPP_CTL_PIN_STATE = 1;
   localparam logic [7:0] SPP_F_OPEN_DRAIN = 8'h04;

   // ************************************************
   // Reset values
   // ************************************************
   localparam logic [7:0] SPP_DIR_RST   = 8'h00;
   localparam logic [7:0] SPP_LAT_RST   = 8'h00;
   localparam logic [7:0] SPP_PUL_RST   = 8'h00;
   localparam logic [7:0] SPP_EN_RST    = 8'h00;
   localparam logic [7:0] SPP_CTL_RST   = 8'h00;

   // ************************************************
   // Bus answers
   // ************************************************
   localparam logic [1:0] SPP_RESP_OKAY   = 2'b00;
   localparam logic [1:0] SPP_RESP_DECERR = 2'b11;

endpackage : spp_pkg
`default_nettype wire

// file: hdl/spp_gpio_ports.sv
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Direction 1 makes the pin an output driving the data latch.
// - Direction 0 makes the pin an input; the latch is not driven.
// - Data writes update the latch and reach output pins one clock after the latch.
// - Data writes to input pins update the latch only; pin stays undriven.
// - Plain data read of an output pin returns the latch.
// - Plain data read of an input pin returns the sampled pin level.
// - Read-modify-write reads always return the latch.
// - A peripheral output enable hands the pin to that peripheral.
// - While a peripheral drives, plain reads return the pin level.
// - Port use needs segment select 0, then port-input control 1.
// - Segment use needs direction 0, segment select 1, then port-input control 1.
// - Segment selects come from enable registers five and six.
// - Reset clears all direction bits; pins start as inputs.
// - Standby with pin-state bit 1 floats pins and holds inputs low.
// - Standby with pin-state bit 0 holds present pin states.
// - Open-drain output writing 1 leaves the pin floating.
// - Port E bit n controls pin n for n 0 to 7.
// - Port F implements bits 0 to 2 only.
// - Port G pull-up connects when set, disconnects while pin outputs low.
// - Port G implements bits 1 and 2 only.
module spp_gpio_ports
   import spp_pkg::*;
#(
   parameter int         ADDR_W     = 8,
   parameter logic [7:0] F_OPEN_DRN = SPP_F_OPEN_DRAIN
)
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Stop or watch mode active
   input  wire logic              standby_req,
   // Sharing peripherals on port E
   input  wire logic [7:0]        periph_e_out,
   input  wire logic [7:0]        periph_e_oe,
   input  wire logic [7:0]        display_drive_line,
   // Port E pins
   input  wire logic [7:0]        pe_in,
   output logic [7:0]             pe_out,
   output logic [7:0]             pe_oe,
   output logic [7:0]             pe_in_level,
   // Port F pins
   input  wire logic [2:0]        pf_in,
   output logic [2:0]             pf_out,
   output logic [2:0]             pf_oe,
   // Port G pins
   input  wire logic [2:0]        pg_in,
   output logic [2:0]             pg_out,
   output logic [2:0]             pg_oe,
   output logic [2:0]             pg_pull
);

   // ************************************************
   // Registers
   // ************************************************
   logic [7:0]  port_e_data_latch_r;
   logic [7:0]  port_e_direction_r;
   logic [7:0]  port_f_data_latch_r;
   logic [7:0]  port_f_direction_r;
   logic [7:0]  port_g_data_latch_r;
   logic [7:0]  port_g_direction_r;
   logic [7:0]  port_g_pullup_enable_r;
   logic [7:0]  ctl_r;
   logic [7:0]  display_enable_reg_five_r;
   logic [7:0]  display_enable_reg_six_r;

   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  awaddr_r;
   logic [7:0]  wdata_r;
   logic        wstrb_r;
   logic        do_wr;

   logic [23:0] sync1_r;
   logic [23:0] sync2_r;
   logic [23:0] sync3_r;
   logic [23:0] flt_r;
   logic [23:0] flt_nxt;

   logic        display_port_input_control;
   logic        standby_pin_state_bit;
   logic        iso;
   logic        hold;
   logic [7:0]  disp_sel;
   logic [7:0]  e_gpio;
   logic [7:0]  e_disp;
   logic [7:0]  e_pin;
   logic [7:0]  f_pin;
   logic [7:0]  g_pin;
   logic [7:0]  e_oe_nxt;
   logic [7:0]  e_out_nxt;
   logic [7:0]  f_oe_nxt;
   logic [7:0]  f_out_nxt;
   logic [7:0]  g_oe_nxt;
   logic [7:0]  g_out_nxt;
   logic [7:0]  g_pull_nxt;
   logic [7:0]  rd_val;
   logic        rd_ok;
   logic        wr_ok;

   assign display_port_input_control = ctl_r[SPP_CTL_PORT_IN];
   assign standby_pin_state_bit      = ctl_r[SPP_CTL_PIN_STATE];
   assign iso  = standby_req & standby_pin_state_bit;
   assign hold = standby_req & ~standby_pin_state_bit;

   // ************************************************
   // Pin input synchroniser
   // ************************************************
   // A level counts once stages two and three agree
   assign flt_nxt = (sync2_r & sync3_r) | (flt_r & (sync2_r ^ sync3_r));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_r <= 24'h000000;
         sync2_r <= 24'h000000;
         sync3_r <= 24'h000000;
         flt_r   <= 24'h000000;
      end
      else
      begin
         sync1_r <= {5'h00, pg_in, 5'h00, pf_in, pe_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         flt_r   <= flt_nxt;
      end
   end

   // Isolated inputs read low so a floating pin cannot leak
   assign e_pin = iso ? 8'h00 : flt_r[7:0];
   assign f_pin = iso ? 8'h00 : (flt_r[15:8] & SPP_F_MASK);
   assign g_pin = iso ? 8'h00 : (flt_r[23:16] & SPP_G_MASK);

   // ************************************************
   // Pin drive
   // ************************************************
   assign disp_sel = {display_enable_reg_six_r[5:0], display_enable_reg_five_r[1:0]};
   assign e_gpio   = {8{display_port_input_control}} & ~disp_sel;
   assign e_disp   = {8{display_port_input_control}} & disp_sel;

   // Peripheral wins; software must have silenced the others
   assign e_oe_nxt  = periph_e_oe | e_disp | (e_gpio & port_e_direction_r);
   assign e_out_nxt = (periph_e_oe & periph_e_out)
                    | (~periph_e_oe & e_disp & display_drive_line)
                    | (~periph_e_oe & ~e_disp & port_e_data_latch_r);
   assign f_oe_nxt  = port_f_direction_r & ~(F_OPEN_DRN & port_f_data_latch_r)
                    & SPP_F_MASK;
   assign f_out_nxt = port_f_data_latch_r & ~F_OPEN_DRN & SPP_F_MASK;
   assign g_oe_nxt  = port_g_direction_r & SPP_G_MASK;
   assign g_out_nxt = port_g_data_latch_r & SPP_G_MASK;
   assign g_pull_nxt = port_g_pullup_enable_r & ~(g_oe_nxt & ~g_out_nxt) & SPP_G_MASK;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pe_oe   <= 8'h00;
         pe_out  <= 8'h00;
         pf_oe   <= 3'h0;
         pf_out  <= 3'h0;
         pg_oe   <= 3'h0;
         pg_out  <= 3'h0;
         pg_pull <= 3'h0;
      end
      else if (iso)
      begin
         pe_oe   <= 8'h00;
         pf_oe   <= 3'h0;
         pg_oe   <= 3'h0;
         pg_pull <= 3'h0;
      end
      else if (!hold)
      begin
         pe_oe   <= e_oe_nxt;
         pe_out  <= e_out_nxt;
         pf_oe   <= f_oe_nxt[2:0];
         pf_out  <= f_out_nxt[2:0];
         pg_oe   <= g_oe_nxt[2:0];
         pg_out  <= g_out_nxt[2:0];
         pg_pull <= g_pull_nxt[2:0];
      end
   end

   // Peripheral input path on port E, blocked until the port is released
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pe_in_level <= 8'h00;
      else
         pe_in_level <= display_port_input_control ? e_pin : 8'h00;
   end

   // ************************************************
   // Write channel
   // ************************************************
   assign do_wr = aw_hold_r & w_hold_r & ~bvalid;

   always_comb
   begin
      wr_ok = 1'b1;
      case (awaddr_r)
         SPP_E_DATA, SPP_E_DIR, SPP_F_DATA, SPP_F_DIR, SPP_G_DATA, SPP_G_DIR,
         SPP_G_PULLUP, SPP_CTL, SPP_DISP_EN5, SPP_DISP_EN6,
         SPP_E_RMW, SPP_F_RMW, SPP_G_RMW: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         awaddr_r  <= 8'h00;
         awready   <= 1'b0;
      end
      else if (awvalid && awready)
      begin
         aw_hold_r <= 1'b1;
         awaddr_r  <= awaddr[7:0];
         awready   <= 1'b0;
      end
      else if (do_wr)
      begin
         aw_hold_r <= 1'b0;
         awready   <= 1'b1;
      end
      else if (!aw_hold_r)
         awready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_r <= 1'b0;
         wdata_r  <= 8'h00;
         wstrb_r  <= 1'b0;
         wready   <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         w_hold_r <= 1'b1;
         wdata_r  <= wdata[7:0];
         wstrb_r  <= wstrb[0];
         wready   <= 1'b0;
      end
      else if (do_wr)
      begin
         w_hold_r <= 1'b0;
         wready   <= 1'b1;
      end
      else if (!w_hold_r)
         wready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= SPP_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? SPP_RESP_OKAY : SPP_RESP_DECERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // Register store; the latch aliases also write the latch
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         port_e_data_latch_r       <= SPP_LAT_RST;
         port_e_direction_r        <= SPP_DIR_RST;
         port_f_data_latch_r       <= SPP_LAT_RST;
         port_f_direction_r        <= SPP_DIR_RST;
         port_g_data_latch_r       <= SPP_LAT_RST;
         port_g_direction_r        <= SPP_DIR_RST;
         port_g_pullup_enable_r    <= SPP_PUL_RST;
         ctl_r                     <= SPP_CTL_RST;
         display_enable_reg_five_r <= SPP_EN_RST;
         display_enable_reg_six_r  <= SPP_EN_RST;
      end
      else if (do_wr && wstrb_r)
      begin
         case (awaddr_r)
            SPP_E_DATA, SPP_E_RMW: port_e_data_latch_r <= wdata_r & SPP_E_MASK;
            SPP_E_DIR:    port_e_direction_r <= wdata_r & SPP_E_MASK;
            SPP_F_DATA, SPP_F_RMW: port_f_data_latch_r <= wdata_r & SPP_F_MASK;
            SPP_F_DIR:    port_f_direction_r <= wdata_r & SPP_F_MASK;
            SPP_G_DATA, SPP_G_RMW: port_g_data_latch_r <= wdata_r & SPP_G_MASK;
            SPP_G_DIR:    port_g_direction_r <= wdata_r & SPP_G_MASK;
            SPP_G_PULLUP: port_g_pullup_enable_r <= wdata_r & SPP_G_MASK;
            SPP_CTL:      ctl_r <= wdata_r & SPP_CTL_MASK;
            SPP_DISP_EN5: display_enable_reg_five_r <= wdata_r & SPP_EN5_MASK;
            SPP_DISP_EN6: display_enable_reg_six_r <= wdata_r & SPP_EN6_MASK;
            default: ;
         endcase
      end
   end

   // ************************************************
   // Read channel
   // ************************************************
   // Output pins driven by a peripheral show the pin, not the latch
   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      case (araddr[7:0])
         SPP_E_DATA: rd_val = (port_e_direction_r & ~periph_e_oe & port_e_data_latch_r)
                            | (~(port_e_direction_r & ~periph_e_oe) & e_pin);
         SPP_F_DATA: rd_val = (port_f_direction_r & port_f_data_latch_r)
                            | (~port_f_direction_r & f_pin);
         SPP_G_DATA: rd_val = (port_g_direction_r & port_g_data_latch_r)
                            | (~port_g_direction_r & g_pin);
         SPP_E_RMW:    rd_val = port_e_data_latch_r;
         SPP_F_RMW:    rd_val = port_f_data_latch_r;
         SPP_G_RMW:    rd_val = port_g_data_latch_r;
         SPP_E_DIR:    rd_val = port_e_direction_r;
         SPP_F_DIR:    rd_val = port_f_direction_r;
         SPP_G_DIR:    rd_val = port_g_direction_r;
         SPP_G_PULLUP: rd_val = port_g_pullup_enable_r;
         SPP_CTL:      rd_val = ctl_r;
         SPP_DISP_EN5: rd_val = display_enable_reg_five_r;
         SPP_DISP_EN6: rd_val = display_enable_reg_six_r;
         default:      rd_ok  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= SPP_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h000000, rd_val};
         rresp   <= rd_ok ? SPP_RESP_OKAY : SPP_RESP_DECERR;
      end
      else if (rvalid && rready)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
      else if (!rvalid)
         arready <= 1'b1;
   end

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_dir_reset_inputs: assert property (disable iff (1'b0) !aresetn |=>
      port_e_direction_r == 8'h00 && port_f_direction_r == 8'h00 && pe_oe == 8'h00)
      else $error("direction or drive not cleared by reset");

   a_gpio_out_drive: assert property (!standby_req && periph_e_oe == 8'h00
      && display_port_input_control && disp_sel == 8'h00 |=>
      pe_oe == $past(port_e_direction_r) && pe_out == $past(port_e_data_latch_r))
      else $error("output pin does not follow latch");

   a_input_undriven: assert property (!standby_req && periph_e_oe == 8'h00
      && disp_sel == 8'h00 |=> (pe_oe & ~$past(port_e_direction_r)) == 8'h00)
      else $error("input pin driven");

   a_periph_override: assert property (!standby_req |=>
      (pe_oe & $past(periph_e_oe)) == $past(periph_e_oe)
      && (pe_out & $past(periph_e_oe)) == ($past(periph_e_out) & $past(periph_e_oe)))
      else $error("peripheral output not on pin");

   a_standby_float: assert property (standby_req && standby_pin_state_bit |=>
      pe_oe == 8'h00 && pf_oe == 3'h0 && pg_oe == 3'h0 && pe_in_level == 8'h00)
      else $error("pins not isolated in standby");

   a_standby_hold: assert property (standby_req && !standby_pin_state_bit |=>
      $stable(pe_out) && $stable(pe_oe) && $stable(pf_oe) && $stable(pg_out))
      else $error("pins changed while held in standby");

   a_open_drain_hiz: assert property (!standby_req && F_OPEN_DRN[2]
      && port_f_data_latch_r[2] |=> !pf_oe[2] && !pf_out[2])
      else $error("open-drain pin driven high");

   a_rmw_latch_read: assert property (arvalid && arready && araddr[7:0] == SPP_E_RMW |=>
      rvalid && rdata == {24'h000000, $past(port_e_data_latch_r)})
      else $error("read-modify-write view not the latch");

   a_input_pin_read: assert property (arvalid && arready && araddr[7:0] == SPP_E_DATA
      && !standby_req |=> (rdata[7:0] & ~$past(port_e_direction_r))
      == ($past(flt_r[7:0]) & ~$past(port_e_direction_r)))
      else $error("input read not the pin level");

   a_unused_bits_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000
      && (!$past(arvalid && arready && araddr[7:0] == SPP_F_DIR) || rdata[7:3] == 5'h00))
      else $error("unimplemented bits read nonzero");

   a_pullup_low_off: assert property ((pg_oe & ~pg_out & pg_pull) == 3'h0)
      else $error("pull-up on while pin drives low");

   a_g_bit0_unused: assert property (pg_oe[0] == 1'b0 && pg_pull[0] == 1'b0)
      else $error("port G bit 0 active");

endmodule : spp_gpio_ports
`default_nettype wire

// file: test/spp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module spp_pin_model
(
   // Clock
   input  wire logic       aclk,
   // Device side
   input  wire logic [7:0] pe_out,
   input  wire logic [7:0] pe_oe,
   input  wire logic [2:0] pf_out,
   input  wire logic [2:0] pf_oe,
   input  wire logic [2:0] pg_out,
   input  wire logic [2:0] pg_oe,
   input  wire logic [2:0] pg_pull,
   // Board drivers on port E
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // Pin levels
   output logic [7:0]      pe_in,
   output logic [2:0]      pf_in,
   output logic [2:0]      pg_in
);
   logic [7:0] e_last = 8'h00;
   logic [2:0] f_last = 3'h0;
   logic [2:0] g_last = 3'h0;

   // Floating lines toggle, so a stale level never passes for a drive
   always_ff @(posedge aclk)
   begin
      e_last <= pe_in;
      f_last <= pf_in;
      g_last <= pg_in;
   end

   // Board drives only where the device has let go
   assign pe_in = (pe_oe & pe_out) | (~pe_oe & ext_en & ext_val) | (~pe_oe & ~ext_en & ~e_last);
   // Open drain pin can only pull low
   assign pf_in = (pf_oe & pf_out) | (~pf_oe & ~f_last);
   // Pull-up holds an undriven pin high
   assign pg_in = (pg_oe & pg_out) | (~pg_oe & (pg_pull | ~g_last));
endmodule : spp_pin_model
`default_nettype wire

// file: test/spp_gpio_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spp_gpio_ports_tb
   import spp_pkg::*;
;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, resp;
   logic        standby_req = 1'b0;
   logic [7:0]  periph_e_out = 8'h00, periph_e_oe = 8'h00, display_drive_line = 8'h00;
   logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
   logic [7:0]  pe_in, pe_out, pe_oe, pe_in_level, d;
   logic [2:0]  pf_in, pf_out, pf_oe, pg_in, pg_out, pg_oe, pg_pull;
   int          mismatches = 0;
   int          tests_run = 0;

   initial
   begin
      forever #10 aclk = ~aclk;
   end

   spp_gpio_ports u_spp_gpio_ports (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .standby_req(standby_req), .periph_e_out(periph_e_out),
      .periph_e_oe(periph_e_oe), .display_drive_line(display_drive_line), .pe_in(pe_in),
      .pe_out(pe_out), .pe_oe(pe_oe), .pe_in_level(pe_in_level), .pf_in(pf_in),
      .pf_out(pf_out), .pf_oe(pf_oe), .pg_in(pg_in), .pg_out(pg_out), .pg_oe(pg_oe),
      .pg_pull(pg_pull));

   spp_pin_model u_spp_pin_model (.aclk(aclk), .pe_out(pe_out), .pe_oe(pe_oe),
      .pf_out(pf_out), .pf_oe(pf_oe), .pg_out(pg_out), .pg_oe(pg_oe), .pg_pull(pg_pull),
      .ext_en(ext_en), .ext_val(ext_val), .pe_in(pe_in), .pf_in(pf_in), .pg_in(pg_in));

   // ************************************************
   // Bus tasks
   // ************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 40) mismatches++;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata[7:0];
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 40) mismatches++;
   endtask : rd

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // Whole run needs well under 3000 cycles
   initial
   begin
      #(20 * 6000);
      mismatches++;
      end_of_test();
   end

   // ************************************************
   // Tests
   // ************************************************
   initial
   begin
      wt(8);
      aresetn <= 1'b1;
      wt(2);
      rd(SPP_E_DIR);
      chk(d, SPP_DIR_RST);
      rd(SPP_F_DIR);
      chk(d, SPP_DIR_RST);
      chk(pe_oe, 8'h00);
      rd(8'h3c);
      chk({6'h0, resp}, {6'h0, SPP_RESP_DECERR});
      chk(d, 8'h00);
      $display("test reset done");
      wr(SPP_CTL, 8'h01);
      wr(SPP_E_DIR, 8'hff);
      wr(SPP_E_DATA, 8'ha5);
      wt(3);
      chk(pe_oe, 8'hff);
      chk(pe_out, 8'ha5);
      rd(SPP_E_DATA);
      chk(d, 8'ha5);
      $display("test output done");
      ext_en  <= 8'hf0;
      ext_val <= 8'h50;
      wr(SPP_E_DIR, 8'h0f);
      wr(SPP_E_DATA, 8'h3c);
      wt(6);
      chk(pe_oe, 8'h0f);
      chk(pe_out & 8'h0f, 8'h0c);
      chk(pe_in_level, 8'h5c);
      rd(SPP_E_DATA);
      chk(d, 8'h5c);
      rd(SPP_E_RMW);
      chk(d, 8'h3c);
      $display("test input done");
      ext_en <= 8'h00;
      periph_e_oe  <= 8'h80;
      periph_e_out <= 8'h80;
      wr(SPP_E_DIR, 8'hff);
      wr(SPP_E_DATA, 8'h00);
      wt(6);
      chk(pe_out, 8'h80);
      rd(SPP_E_DATA);
      chk(d, 8'h80);
      rd(SPP_E_RMW);
      chk(d, 8'h00);
      periph_e_oe <= 8'h00;
      $display("test peripheral done");
      display_drive_line <= 8'h96;
      wr(SPP_E_DIR, 8'h00);
      wr(SPP_DISP_EN5, 8'hff);
      wt(3);
      chk(pe_oe, 8'h03);
      rd(SPP_DISP_EN5);
      chk(d, 8'h03);
      wr(SPP_DISP_EN6, 8'h3f);
      wt(3);
      chk(pe_oe, 8'hff);
      chk(pe_out, 8'h96);
      $display("test segment done");
      standby_req <= 1'b1;
      display_drive_line <= 8'h00;
      wt(4);
      chk(pe_out, 8'h96);
      standby_req <= 1'b0;
      wt(3);
      chk(pe_out, 8'h00);
      wr(SPP_CTL, 8'h03);
      standby_req <= 1'b1;
      ext_en  <= 8'hff;
      ext_val <= 8'hff;
      wt(6);
      chk(pe_oe, 8'h00);
      chk(pe_in_level, 8'h00);
      rd(SPP_E_DATA);
      chk(d, 8'h00);
      standby_req <= 1'b0;
      wr(SPP_CTL, 8'h01);
      $display("test standby done");
      wr(SPP_F_DIR, 8'hff);
      rd(SPP_F_DIR);
      chk(d, 8'h07);
      wr(SPP_F_DATA, 8'h07);
      wt(3);
      chk({5'h0, pf_oe}, 8'h03);
      chk({5'h0, pf_out}, 8'h03);
      rd(SPP_F_DATA);
      chk(d, 8'h07);
      wr(SPP_F_DATA, 8'h03);
      wt(3);
      chk({5'h0, pf_oe}, 8'h07);
      $display("test port f done");
      wr(SPP_G_DIR, 8'hff);
      wr(SPP_G_DATA, 8'h04);
      wr(SPP_G_PULLUP, 8'hff);
      wt(3);
      chk({5'h0, pg_oe}, 8'h06);
      chk({5'h0, pg_out}, 8'h04);
      chk({5'h0, pg_pull}, 8'h04);
      rd(SPP_G_PULLUP);
      chk(d, 8'h06);
      wr(SPP_G_DIR, 8'h00);
      wt(6);
      rd(SPP_G_DATA);
      chk(d, 8'h06);
      wstrb <= 4'he;
      wr(SPP_G_DATA, 8'h02);
      wstrb <= 4'hf;
      rd(SPP_G_RMW);
      chk(d, 8'h04);
      wr(8'h3c, 8'hff);
      chk({6'h0, resp}, {6'h0, SPP_RESP_DECERR});
      $display("test port g done");
      end_of_test();
   end
endmodule : spp_gpio_ports_tb
`default_nettype wire
